// ==== rtl/ptr_agen_pkg.sv ====
// Purpose : Constants and types for indexed pointer address generation
// Assumes : 16-bit pointers, 7-bit high part, 23-bit word addresses
// Notes   : Mode codes are a local encoding chosen for the decode side
//
// Overview of operation
// - Index-offset mode addresses pointer high part with pointer plus index0; pointer kept.
// - Second double-word address is first plus one if even, minus one if odd.
// - Bit-reversed add addresses with old pointer, then adds index reverse-carry.
// - Bit-reversed subtract addresses with old pointer, then subtracts reverse-borrow.
// - Compat bit set selects pointer zero as index instead of index0.
// - Circular pointer in bit-reversed mode adds buffer start; update never wraps.
// - Add-second-index addresses with current pointer, then adds index1.
// - Subtract-second-index addresses with current pointer, then subtracts index1.
// - Second-index offset addresses pointer plus index1; pointer kept.
// - Constant-offset adds sign-extended 16-bit constant to pointer; pointer kept.
// - Constant-carrying instruction uses 2-byte extension and never pairs in parallel.
// - Pre-modify constant writes pointer plus constant back, then addresses with it.
// - Post-modify address is high part joined to pointer, plus start if circular.
// - Double-word load sends first word to named register, second to its pair.
// - Double-word post-modify makes both addresses from original pointer, one update.
// - Index-offset with compat bit uses pointer zero as offset; pointer kept.
package ptr_agen_pkg;

    //------------------------------------------------------------
    // Widths
    //------------------------------------------------------------
    localparam int PTR_W   = 16;
    localparam int HIGH_W  = 7;
    localparam int ADDR_W  = PTR_W + HIGH_W;
    localparam int MODE_W  = 4;
    localparam int CONST_W = 16;
    localparam int EXT_BYTES = 2;                       // Constant extension length

    //------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
    localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;

    //------------------------------------------------------------
    // Addressing modes
    //------------------------------------------------------------
    typedef enum logic [MODE_W-1:0] {
        MODE_IDX_OFS  = 4'h0,   // Base plus index0 or pointer zero
        MODE_BR_ADD   = 4'h1,   // Post add, reverse carry
        MODE_BR_SUB   = 4'h2,   // Post subtract, reverse borrow
        MODE_IDX1_ADD  = 4'h3,  // Post add index1
        MODE_IDX1_SUB  = 4'h4,  // Post subtract index1
        MODE_IDX1_OFS  = 4'h5,  // Base plus index1
        MODE_CONST_OFS = 4'h6,  // Base plus constant
        MODE_CONST_PRE = 4'h7   // Pre-modify by constant
    } agen_mode_e;

    //------------------------------------------------------------
    // Sequencer states, Gray along issue path except the idle-to-second step, which flips both bits
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_FIRST  = 2'h1,
        ST_SECOND = 2'h3
    } agen_state_e;

endpackage : ptr_agen_pkg

// ==== rtl/rev_carry_addsub.sv ====
// Purpose : Add or subtract with carries flowing from MSB toward LSB
// Assumes : Combinational, width set by parameter
// Notes   : Subtract is reverse add of two's complement in reversed order
`timescale 1ns/100ps
module rev_carry_addsub
    import ptr_agen_pkg::*;
#(
    parameter int W = PTR_W
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         sub,
    output logic      [W-1:0] y
);

    logic [W-1:0] ar;
    logic [W-1:0] br;
    logic [W-1:0] sr;

    // Bit-reverse operands, add normally, reverse back
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_rev
            assign ar[i]     = a[W-1-i];
            assign br[i]     = b[W-1-i];
            assign y[W-1-i]  = sr[i];
        end
    endgenerate

    // Borrow form: reversed negate is plain negate of reversed value
    assign sr = sub ? (ar - br) : (ar + br);

endmodule : rev_carry_addsub

// ==== rtl/ptr_agen.sv ====
// Purpose : Indirect operand address generation with pointer update
// Assumes : Decode holds request fields stable in the request cycle
// Notes   : Two-cycle address issue for double-word accesses;
//           every output is a register field, frozen while clock enable is low
`timescale 1ns/100ps
module ptr_agen
    import ptr_agen_pkg::*;
#(
    parameter int PW = PTR_W,
    parameter int HW = HIGH_W
) (
    input  wire logic                  MCLK,
    input  wire logic                  RST_B,
    input  wire logic                  CE,
    input  wire logic                  REQ,
    input  wire logic [MODE_W-1:0]     MODE,
    input  wire logic                  DBL,
    input  wire logic                  COMPAT_MODE_BIT,
    input  wire logic                  CIRC_EN,
    input  wire logic [PW-1:0]         AUX_POINTER,
    input  wire logic [HW-1:0]         POINTER_HIGH_PART,
    input  wire logic [PW-1:0]         INDEX_REG0,
    input  wire logic [PW-1:0]         INDEX_REG1,
    input  wire logic [PW-1:0]         AUX_POINTER0,
    input  wire logic [PW-1:0]         BUFFER_START_ADDR,
    input  wire logic [CONST_W-1:0]    OFFSET_CONST16,
    output logic                       BUSY,
    output logic                       ADDR_VALID,
    output logic [HW+PW-1:0]           ADDR,
    output logic                       WORD_SEL,
    output logic                       PTR_WE,
    output logic [PW-1:0]              PTR_NEW,
    output logic                       NO_PARALLEL,
    output logic [1:0]                 EXT_LEN
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        agen_state_e         st;
        logic                busy;
        logic                valid;
        logic [HW+PW-1:0]    addr;
        logic [HW+PW-1:0]    addr2;
        logic                word_sel;
        logic                we;
        logic [PW-1:0]       ptr_new;
        logic                we_pend;
        logic [PW-1:0]       ptr_pend;
        logic                no_par;
        logic [1:0]          ext_len;
    } agen_s;

    // Registered state and its next value
    agen_s s_r;
    agen_s s_nxt;

    // Datapath nets between operand select and sequencer
    logic [PW-1:0]      idx0;
    logic [PW-1:0]      base;
    logic [PW-1:0]      ofs;
    logic               use_base_ofs;
    logic [PW-1:0]      lin;
    logic [HW+PW-1:0]   first;
    logic [PW-1:0]      brev;
    logic [PW-1:0]      upd;
    logic               upd_en;
    agen_mode_e         mode;

    //------------------------------------------------------------
    // Operand select
    //------------------------------------------------------------
    // Mode code cast to the enum; codes 8 to 15 fall to default
    assign mode = agen_mode_e'(MODE);

    // Index select by compatibility bit
    assign idx0 = COMPAT_MODE_BIT ? AUX_POINTER0 : INDEX_REG0;

    // Reverse-carry update for bit-reversed modes
    // Subtract only in the reverse-borrow mode
    rev_carry_addsub #(.W(PW)) u_rev (
        .a   (AUX_POINTER),
        .b   (idx0),
        .sub (mode == MODE_BR_SUB),
        .y   (brev)
    );

    // Offset and pointer update per mode
    always_comb begin
        ofs          = '0;
        upd          = AUX_POINTER;
        upd_en       = 1'b0;
        use_base_ofs = 1'b0;
        case (mode)
            MODE_IDX_OFS: begin
                // Offset is index0, or pointer zero in compat mode
                ofs = idx0;
            end
            MODE_BR_ADD, MODE_BR_SUB: begin
                // Address uses the old pointer; the update skips the
                // buffer start, so it is never wrapped into the buffer
                upd    = brev;
                upd_en = 1'b1;
            end
            MODE_IDX1_ADD: begin
                upd    = AUX_POINTER + INDEX_REG1;
                upd_en = 1'b1;
            end
            MODE_IDX1_SUB: begin
                upd    = AUX_POINTER - INDEX_REG1;
                upd_en = 1'b1;
            end
            // Base-plus-offset forms other than pre-modify never write the pointer
            MODE_IDX1_OFS: begin
                ofs = INDEX_REG1;
            end
            MODE_CONST_OFS: begin
                ofs = OFFSET_CONST16;
            end
            MODE_CONST_PRE: begin
                // Address adds the constant to the base; the written-back pointer is pointer plus constant, without buffer start
                ofs    = OFFSET_CONST16;
                upd    = AUX_POINTER + OFFSET_CONST16;
                upd_en = 1'b1;
            end
            default: begin
                // Codes 8 to 15 address the base with no offset, no update
                ofs = '0;
            end
        endcase
        use_base_ofs = (ofs != '0);
    end

    //------------------------------------------------------------
    // Address forming
    //------------------------------------------------------------
    // Buffer start added only for circular pointers
    assign base  = CIRC_EN ? (AUX_POINTER + BUFFER_START_ADDR) : AUX_POINTER;
    assign lin   = use_base_ofs ? (base + ofs) : base;
    assign first = {POINTER_HIGH_PART, lin};

    //------------------------------------------------------------
    // Issue sequencer
    //------------------------------------------------------------
    always_comb begin
        // Pulses drop unless a branch raises them
        s_nxt       = s_r;
        s_nxt.valid = 1'b0;
        s_nxt.we    = 1'b0;
        case (s_r.st)
            ST_IDLE: begin
                // Operands sampled only here; later cycles replay stored values
                if (REQ) begin
                    s_nxt.st       = DBL ? ST_SECOND : ST_FIRST;
                    s_nxt.busy     = 1'b1;
                    s_nxt.valid    = 1'b1;
                    s_nxt.addr     = first;
                    s_nxt.word_sel = 1'b0;
                    // Second address pairs by parity of the first
                    s_nxt.addr2    = first[0] ? (first - 1'b1) : (first + 1'b1);
                    s_nxt.we_pend  = upd_en;
                    s_nxt.ptr_pend = upd;
                    // Constant forms need the extension and run alone
                    s_nxt.no_par   = (mode == MODE_CONST_OFS) ||
                                     (mode == MODE_CONST_PRE);
                    s_nxt.ext_len  = s_nxt.no_par ? 2'(EXT_BYTES) : 2'h0;
                    // Single access writes the pointer with its only address
                    if (!DBL) begin
                        s_nxt.we      = upd_en;
                        s_nxt.ptr_new = upd;
                    end
                end
            end
            ST_SECOND: begin
                // Second word from original pointer, with the single update in the same cycle
                // Busy stays high through the second word
                s_nxt.st       = ST_FIRST;
                s_nxt.valid    = 1'b1;
                s_nxt.addr     = s_r.addr2;
                s_nxt.word_sel = 1'b1;
                s_nxt.we       = s_r.we_pend;
                s_nxt.ptr_new  = s_r.ptr_pend;
            end
            ST_FIRST: begin
                // Tail cycle: flags drop and busy is released
                s_nxt.st      = ST_IDLE;
                s_nxt.busy    = 1'b0;
                s_nxt.no_par  = 1'b0;
                s_nxt.ext_len = 2'h0;
            end
            default: begin
                // Unused encoding recovers to idle
                s_nxt.st   = ST_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    // State register
    // Clock enable low holds every field, pulses included
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            s_r <= '{st: ST_IDLE, busy: 1'b0, valid: 1'b0, addr: ADDR_RST, addr2: ADDR_RST,
                     word_sel: 1'b0, we: 1'b0, ptr_new: PTR_RST, we_pend: 1'b0,
                     ptr_pend: PTR_RST, no_par: 1'b0, ext_len: 2'h0};
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    // Each output is a register field, no logic after the flops
    assign BUSY        = s_r.busy;
    assign ADDR_VALID  = s_r.valid;
    assign ADDR        = s_r.addr;
    assign WORD_SEL    = s_r.word_sel;
    assign PTR_WE      = s_r.we;
    assign PTR_NEW     = s_r.ptr_new;
    assign NO_PARALLEL = s_r.no_par;
    assign EXT_LEN     = s_r.ext_len;

endmodule : ptr_agen

// ==== verif/ptr_agen_sva.sv ====
// Purpose: Port-level checks of address issue and pointer update
// Assumes: Bound into ptr_agen from the bench top file
// Notes  : Helper sum holds base pointer with optional buffer start
`timescale 1ns/100ps
module ptr_agen_sva
    import ptr_agen_pkg::*;
#(
    parameter int PW = PTR_W,
    parameter int HW = HIGH_W
) (
    input wire logic                MCLK,
    input wire logic                RST_B,
    input wire logic                CE,
    input wire logic                REQ,
    input wire logic [MODE_W-1:0]   MODE,
    input wire logic                DBL,
    input wire logic                COMPAT_MODE_BIT,
    input wire logic                CIRC_EN,
    input wire logic [PW-1:0]       AUX_POINTER,
    input wire logic [HW-1:0]       POINTER_HIGH_PART,
    input wire logic [PW-1:0]       INDEX_REG0,
    input wire logic [PW-1:0]       INDEX_REG1,
    input wire logic [PW-1:0]       AUX_POINTER0,
    input wire logic [PW-1:0]       BUFFER_START_ADDR,
    input wire logic [CONST_W-1:0]  OFFSET_CONST16,
    input wire logic                BUSY,
    input wire logic                ADDR_VALID,
    input wire logic [HW+PW-1:0]    ADDR,
    input wire logic                WORD_SEL,
    input wire logic                PTR_WE,
    input wire logic [PW-1:0]       PTR_NEW,
    input wire logic                NO_PARALLEL,
    input wire logic [1:0]          EXT_LEN
);
    // Request taken, base address and selected index
    wire logic          take = CE && REQ && !BUSY;
    wire logic [PW-1:0] base = AUX_POINTER + (CIRC_EN ? BUFFER_START_ADDR : '0);
    wire logic [PW-1:0] idx0 = COMPAT_MODE_BIT ? AUX_POINTER0 : INDEX_REG0;

    // Bit order flip for the reverse-carry reference
    function automatic logic [PW-1:0] flip(input logic [PW-1:0] x);
        flip = {<<{x}};
    endfunction : flip

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    sequence s_pair;
        (ADDR_VALID && !WORD_SEL && !PTR_WE) ##1 (ADDR_VALID && WORD_SEL);
    endsequence
    property p_first; take |=> BUSY && ADDR_VALID && !WORD_SEL; endproperty
    a_first: assert property (p_first) else $error("first address missing");
    property p_dbl; take && DBL |=> s_pair; endproperty
    a_dbl: assert property (p_dbl) else $error("double access order wrong");
    property p_pair;
        ADDR_VALID && WORD_SEL |->
            ADDR == ($past(ADDR[0]) ? $past(ADDR) - 1'b1 : $past(ADDR) + 1'b1);
    endproperty
    a_pair: assert property (p_pair) else $error("second address wrong");
    property p_post;
        take && MODE inside {[1:4]} |=> ADDR == {$past(POINTER_HIGH_PART), $past(base)};
    endproperty
    a_post: assert property (p_post) else $error("post-modify address wrong");
    property p_idx;
        take && MODE == MODE_IDX_OFS |=>
            ADDR[PW-1:0] == $past(base + (COMPAT_MODE_BIT ? AUX_POINTER0 : INDEX_REG0));
    endproperty
    a_idx: assert property (p_idx) else $error("index offset wrong");
    property p_ofs;
        take && MODE inside {MODE_IDX1_OFS, MODE_CONST_OFS} |=> ADDR[PW-1:0] ==
            $past(base + (MODE == MODE_IDX1_OFS ? INDEX_REG1 : OFFSET_CONST16));
    endproperty
    a_ofs: assert property (p_ofs) else $error("base offset wrong");
    property p_keep;
        take && MODE inside {MODE_IDX_OFS, MODE_IDX1_OFS, MODE_CONST_OFS} |=> !PTR_WE [*2];
    endproperty
    a_keep: assert property (p_keep) else $error("pointer written");
    property p_idx1upd;
        take && !DBL && MODE inside {MODE_IDX1_ADD, MODE_IDX1_SUB} |=> PTR_WE && PTR_NEW ==
            $past(MODE == MODE_IDX1_ADD ? AUX_POINTER + INDEX_REG1 : AUX_POINTER - INDEX_REG1);
    endproperty
    a_idx1upd: assert property (p_idx1upd) else $error("index1 update wrong");
    property p_brupd;
        take && !DBL && MODE inside {MODE_BR_ADD, MODE_BR_SUB} |=> PTR_WE && PTR_NEW ==
            $past(MODE == MODE_BR_SUB ? flip(flip(AUX_POINTER) - flip(idx0))
                                      : flip(flip(AUX_POINTER) + flip(idx0)));
    endproperty
    a_brupd: assert property (p_brupd)
        else $error("bit-reversed update wrong");
    property p_hold;
        !CE |=> $stable(BUSY) && $stable(ADDR_VALID) && $stable(ADDR) && $stable(PTR_WE) &&
            $stable(PTR_NEW) && $stable(NO_PARALLEL);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved with clock enable low");
    property p_pre;
        take && !DBL && MODE == MODE_CONST_PRE |=> PTR_WE &&
            PTR_NEW == $past(AUX_POINTER + OFFSET_CONST16) &&
            ADDR[PW-1:0] == $past(base + OFFSET_CONST16);
    endproperty
    a_pre: assert property (p_pre) else $error("pre-modify wrong");
    property p_nopar;
        take && MODE inside {MODE_CONST_OFS, MODE_CONST_PRE} |=> NO_PARALLEL && EXT_LEN == 2'h2;
    endproperty
    a_nopar: assert property (p_nopar) else $error("extension flags wrong");
endmodule : ptr_agen_sva

// ==== verif/ptr_agen_bench.sv ====
// Purpose: Self-checking bench for pointer address generation
// Assumes: Clock enable dropped for random one-cycle stalls; fixed seed
// Notes  : Driver queues expected addresses, monitor pops and compares
`timescale 1ns/100ps
module ptr_agen_bench;
    import ptr_agen_pkg::*;
    logic              MCLK = 1'b0, RST_B = 1'b0, CE = 1'b1, REQ = 1'b0, DBL = 1'b0;
    logic              COMPAT_MODE_BIT = 1'b0, CIRC_EN = 1'b0;
    logic [MODE_W-1:0] MODE = 4'h0;
    logic [HIGH_W-1:0] POINTER_HIGH_PART = 7'h00;
    logic [PTR_W-1:0]  AUX_POINTER = 16'h0000, INDEX_REG0 = 16'h0000, INDEX_REG1 = 16'h0000;
    logic [PTR_W-1:0]  AUX_POINTER0 = 16'h0000, BUFFER_START_ADDR = 16'h0000;
    logic [PTR_W-1:0]  OFFSET_CONST16 = 16'h0000, PTR_NEW;
    logic              BUSY, ADDR_VALID, WORD_SEL, PTR_WE, NO_PARALLEL;
    logic [ADDR_W-1:0] ADDR;
    logic [1:0]        EXT_LEN;
    logic [43:0]       expq[$];
    int                error_cnt = 0, compares = 0;

    ptr_agen DUT (
        .MCLK              (MCLK),
        .RST_B             (RST_B),
        .CE                (CE),
        .REQ               (REQ),
        .MODE              (MODE),
        .DBL               (DBL),
        .COMPAT_MODE_BIT   (COMPAT_MODE_BIT),
        .CIRC_EN           (CIRC_EN),
        .AUX_POINTER       (AUX_POINTER),
        .POINTER_HIGH_PART (POINTER_HIGH_PART),
        .INDEX_REG0        (INDEX_REG0),
        .INDEX_REG1        (INDEX_REG1),
        .AUX_POINTER0      (AUX_POINTER0),
        .BUFFER_START_ADDR (BUFFER_START_ADDR),
        .OFFSET_CONST16    (OFFSET_CONST16),
        .BUSY              (BUSY),
        .ADDR_VALID        (ADDR_VALID),
        .ADDR              (ADDR),
        .WORD_SEL          (WORD_SEL),
        .PTR_WE            (PTR_WE),
        .PTR_NEW           (PTR_NEW),
        .NO_PARALLEL       (NO_PARALLEL),
        .EXT_LEN           (EXT_LEN)
    );
    always #2 MCLK = ~MCLK;

    function automatic logic [15:0] rev16(input logic [15:0] x);
        rev16 = {<<{x}};
    endfunction : rev16

    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // One request with queued expectations, plus a refused request while busy for double accesses
    task automatic issue(input logic [3:0] m, input logic d);
        logic [15:0] idx, off, nw, b;
        logic [22:0] a;
        logic        we, np, stall;
        int          n;
        AUX_POINTER = 16'($urandom);
        INDEX_REG0 = 16'($urandom);
        INDEX_REG1 = 16'($urandom);
        AUX_POINTER0 = 16'($urandom);
        BUFFER_START_ADDR = 16'($urandom);
        OFFSET_CONST16 = 16'($urandom);
        POINTER_HIGH_PART = 7'($urandom);
        {COMPAT_MODE_BIT, CIRC_EN} = 2'($urandom);
        {MODE, DBL, REQ} = {m, d, 1'b1};
        stall = 1'($urandom);
        CE = ~stall;
        idx = COMPAT_MODE_BIT ? AUX_POINTER0 : INDEX_REG0;
        b = AUX_POINTER + (CIRC_EN ? BUFFER_START_ADDR : 16'h0000);
        case (m)
            4'h0: off = idx;
            4'h5: off = INDEX_REG1;
            4'h6, 4'h7: off = OFFSET_CONST16;
            default: off = 16'h0000;
        endcase
        case (m)
            4'h1: nw = rev16(rev16(AUX_POINTER) + rev16(idx));
            4'h2: nw = rev16(rev16(AUX_POINTER) - rev16(idx));
            4'h3: nw = AUX_POINTER + INDEX_REG1;
            4'h4: nw = AUX_POINTER - INDEX_REG1;
            4'h7: nw = AUX_POINTER + OFFSET_CONST16;
            default: nw = 16'h0000;
        endcase
        we = m inside {[1:4], 7};
        np = m inside {6, 7};
        a = {POINTER_HIGH_PART, b + off};
        expq.push_back({a, 1'b0, we & ~d, (we & ~d) ? nw : 16'h0000, np, np ? 2'h2 : 2'h0});
        if (d) begin
            expq.push_back({a[0] ? a - 23'h1 : a + 23'h1, 1'b1, we, we ? nw : 16'h0000, np,
                            np ? 2'h2 : 2'h0});
        end
        @(posedge MCLK);
        if (stall) begin
            #1 CE = 1'b1;
            @(posedge MCLK);
        end
        #1 REQ = 1'b0;
        if (d) begin
            @(posedge MCLK);
            #1 REQ = 1'b1;
            @(posedge MCLK);
            #1 REQ = 1'b0;
        end
        n = 0;
        do begin
            @(posedge MCLK);
            #1 n++;
        end while (BUSY !== 1'b0 && n < 8);
        chk(44'({BUSY, 8'(n)}), 44'h1);
    endtask : issue

    // Monitor: every address or pointer write must match the oldest note
    always @(negedge MCLK) begin
        if (ADDR_VALID === 1'b1 || PTR_WE === 1'b1) begin
            chk({ADDR, WORD_SEL, PTR_WE, PTR_WE === 1'b1 ? PTR_NEW : 16'h0000, NO_PARALLEL,
                 EXT_LEN}, expq.size() > 0 ? expq.pop_front() : 44'h0);
        end
    end

    // Main sequence
    initial begin
        void'($urandom(64));
        repeat (8) @(posedge MCLK);
        #1 RST_B = 1'b1;
        chk(44'({BUSY, ADDR_VALID, ADDR, PTR_WE, PTR_NEW}), 44'h0);
        for (int m = 0; m < 16; m++) begin
            for (int d = 0; d < 2; d++) begin
                issue(4'(m), 1'(d));
            end
        end
        repeat (200) issue(4'($urandom), 1'($urandom));
        repeat (4) @(posedge MCLK);
        chk(44'(expq.size()), 44'h0);
        close_out();
    end

    // Watchdog
    initial begin
        #20000;
        error_cnt++;
        close_out();
    end
endmodule : ptr_agen_bench

bind ptr_agen ptr_agen_sva #(.PW(PW), .HW(HW)) chk_i (
    .MCLK              (MCLK),
    .RST_B             (RST_B),
    .CE                (CE),
    .REQ               (REQ),
    .MODE              (MODE),
    .DBL               (DBL),
    .COMPAT_MODE_BIT   (COMPAT_MODE_BIT),
    .CIRC_EN           (CIRC_EN),
    .AUX_POINTER       (AUX_POINTER),
    .POINTER_HIGH_PART (POINTER_HIGH_PART),
    .INDEX_REG0        (INDEX_REG0),
    .INDEX_REG1        (INDEX_REG1),
    .AUX_POINTER0      (AUX_POINTER0),
    .BUFFER_START_ADDR (BUFFER_START_ADDR),
    .OFFSET_CONST16    (OFFSET_CONST16),
    .BUSY              (BUSY),
    .ADDR_VALID        (ADDR_VALID),
    .ADDR              (ADDR),
    .WORD_SEL          (WORD_SEL),
    .PTR_WE            (PTR_WE),
    .PTR_NEW           (PTR_NEW),
    .NO_PARALLEL       (NO_PARALLEL),
    .EXT_LEN           (EXT_LEN)
);
